// >>> bench/supply_model.sv
// external supply model: turns the control code into an output voltage
// assumes code 16'hffff means +10 V and supply_on gates the output
`timescale 1ns/1ps
module supply_model (
  // drive from the controller
  input  wire logic [15:0] code,
  input  wire logic        on,
  // supply output in millivolts
  output int               mv
);
  // linear supply, dead while the control is not applied
  assign mv = on ? (int'(code) * 10000) / 65535 : 0;
endmodule

// >>> bench/test_warmup_supply_onoff_control.sv
// self-checking bench for the warm-up supply controller
// assumes warmup_ctrl, warmup_pkg and supply_model are compiled before it
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  miscompares++; $display("unexpected %0t got %h exp %h", $time, g, e); \
  end end
module test_warmup_supply_onoff_control;
  logic        sys_clk, rst_b, reg_wr, reg_rd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [23:0] rdg [4];
  logic [3:0]  smp;
  logic [15:0] supply_code;
  logic        supply_on;
  int          mv, miscompares, n_compared;
  int          pct, raw, sp, sel, pol, exp_on, exp_rng, last;
  ////////////////////////////////////////////////////////////////////////
  // design and supply
  warmup_ctrl i_warmup_ctrl (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reading_a(rdg[0]),
    .reading_b(rdg[1]), .reading_c(rdg[2]), .reading_d(rdg[3]),
    .sample_a(smp[0]), .sample_b(smp[1]), .sample_c(smp[2]),
    .sample_d(smp[3]), .supply_code(supply_code), .supply_on(supply_on));
  supply_model i_supply_model (.code(supply_code), .on(supply_on), .mv(mv));
  ////////////////////////////////////////////////////////////////////////
  // register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdt(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // compare the outputs with the model once they have settled
  task automatic check;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(supply_on, exp_on[0])
    `CHK(supply_code, exp_on ? 16'(pct * 65535 / 100) : 16'h0)
    if (!exp_on) `CHK(mv, 0)
    else `CHK(mv, (pct * 65535 / 100) * 10000 / 65535)
    rdt(warmup_pkg::STATUS_OFS);
    `CHK(rd[1:0], {exp_rng[0], exp_on[0]})
    `CHK(rd[31:8], 24'(last))
  endtask
  // control write: warm-up mode always selected
  task automatic ctrl(input int p, input int s, input int r);
    wr(warmup_pkg::CTRL_OFS, 32'((r << 4) | (s << 2) | (p << 1) | 1));
    pol = p;
    sel = s;
    exp_rng = r;
    exp_on = r;
    check;
  endtask
  // one reading on input ch, then the model's on/off decision
  task sample(input int ch, input int val);
    @(posedge sys_clk);
    rdg[ch] <= 24'(val);
    smp[ch] <= 1'b1;
    @(posedge sys_clk);
    smp <= 4'h0;
    if (ch == sel) last = val;
    if (ch == sel && exp_rng) begin
      if (exp_on && val >= sp) begin
        exp_on = 0;
        if (!pol) exp_rng = 0;
      end else if (!exp_on && pol && val + 1000 <= sp) exp_on = 1;
    end
    check;
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // clock, watchdog and test sequence
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #200us;
    miscompares++;
    print_verdict;
  end
  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, smp} = '0;
    rdg = '{default: 24'h0};
    pct = 100;
    sel = 0;
    exp_on = 0;
    exp_rng = 0;
    last = 0;
    void'($urandom(7153));
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdt(warmup_pkg::CTRL_OFS);
    `CHK(rd, 32'h2)
    rdt(warmup_pkg::PCT_OFS);
    `CHK(rd, 32'h64)
    rdt(8'h10);
    `CHK(rd, 32'h0)
    // range on without warm-up mode keeps the supply dead
    wr(warmup_pkg::CTRL_OFS, 32'h12);
    exp_rng = 1;
    check;
    // continuous policy over every input and percentage corners
    for (int i = 0; i < 8; i++) begin
      raw = (i == 0) ? 0 : (i == 1) ? 200 : $urandom_range(100);
      pct = (raw > 100) ? 100 : raw;
      sp = $urandom_range(50000, 2000);
      wr(warmup_pkg::SETPOINT_OFS, 32'(sp));
      wr(warmup_pkg::PCT_OFS, 32'(raw));
      rdt(warmup_pkg::PCT_OFS);
      `CHK(rd, 32'(pct))
      ctrl(1, i % 4, 0);
      ctrl(1, i % 4, 1);
      sample((i + 1) % 4, sp + 5);
      sample(i % 4, sp + i);
      sample(i % 4, sp - 999);
      sample(i % 4, sp - 1000);
      ctrl(1, i % 4, 0);
    end
    // auto-off policy: disarm at setpoint, manual restart
    ctrl(0, 3, 1);
    sample(3, sp - 1);
    sample(3, sp);
    rdt(warmup_pkg::CTRL_OFS);
    `CHK(rd[4], 1'b0)
    sample(3, 0);
    ctrl(0, 3, 1);
    sample(3, sp + 100);
    print_verdict;
  end
endmodule

// >>> inc/warmup_pkg.sv
// constants for the warm-up supply on/off controller
// assumes readings and setpoint are unsigned millikelvin values
package warmup_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] PCT_OFS      = 8'h04;
  localparam logic [7:0] SETPOINT_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS   = 8'h0c;

  // control register field positions
  localparam int MODE_BIT   = 0;  // output_mode_command: warm-up selected
  localparam int POLICY_BIT = 1;  // 1 continuous, 0 auto-off
  localparam int SEL_LO     = 2;  // control input select, two bits
  localparam int RANGE_BIT  = 4;  // heater range on

  // status register field positions
  localparam int STAT_ON_BIT    = 0;
  localparam int STAT_RANGE_BIT = 1;
  localparam int STAT_RD_LO     = 8;

  // reset values
  localparam logic        MODE_RST     = 1'b0;
  localparam logic        POLICY_RST   = 1'b1;
  localparam logic [1:0]  SEL_RST      = 2'h0;
  localparam logic        RANGE_RST    = 1'b0;
  localparam logic [6:0]  PCT_RST      = 7'h64;  // 100 percent
  localparam logic [23:0] SETPOINT_RST = 24'h000000;

  // scaling and hysteresis
  localparam logic [6:0]  PCT_MAX   = 7'h64;     // 100 percent
  localparam logic [15:0] FS_CODE   = 16'hffff;  // +10 V full scale
  localparam logic [24:0] HYST_MK   = 25'h0003e8; // 1 K in millikelvin

  // controller states
  typedef enum logic [2:0] {
    OFF_ST  = 3'b001,
    HEAT_ST = 3'b010,
    REST_ST = 3'b100
  } warm_state_t;

endpackage

// >>> src/pct_scale.sv
// scales the full-scale output code by a warm-up percentage
// assumes the percentage never exceeds 100, the writer clamps it
`timescale 1ns/1ps
module pct_scale (
  // percentage in, 0 to 100
  input  wire logic [6:0]  pct,
  // scaled output code
  output wire logic [15:0] code
);

  logic [22:0] product;
  logic [22:0] quotient;

  // full scale times percent, divided by one hundred
  assign product  = 23'(pct) * 23'(warmup_pkg::FS_CODE);
  assign quotient = product / 23'(warmup_pkg::PCT_MAX);
  assign code     = quotient[15:0];

endmodule

// >>> src/warmup_ctrl.sv
// warm-up supply on/off controller for one unpowered analog output
// assumes readings and strobes come from measurement logic on sys_clk
//
// What this block does
// - In warm-up mode the output is the external supply's control voltage.
// - Feedback comes from the sensor picked by the control input select.
// - While on, the output is full scale times the percentage, default 100.
// - The voltage is applied only once heater range is On, never while Off.
// - Auto-off: at setpoint the output goes to 0 V and heater range clears.
// - Auto-off: setting heater range On again restarts the heating cycle.
// - Continuous: off at setpoint, on again once 1 K below setpoint.
// - Continuous never clears heater range itself and is the reset policy.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module warmup_ctrl (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // sensor readings in millikelvin with sample strobes
  input  wire logic [23:0] reading_a,
  input  wire logic [23:0] reading_b,
  input  wire logic [23:0] reading_c,
  input  wire logic [23:0] reading_d,
  input  wire logic        sample_a,
  input  wire logic        sample_b,
  input  wire logic        sample_c,
  input  wire logic        sample_d,
  // drive to the external supply
  output logic      [15:0] supply_code,
  output logic             supply_on
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic        mode_reg;
  logic        policy_reg;
  logic [1:0]  sel_reg;
  logic        range_reg;
  logic        range_next;
  logic [6:0]  pct_reg;
  logic [23:0] setpoint_reg;
  logic [23:0] last_reading_reg;
  warmup_pkg::warm_state_t state_reg;
  warmup_pkg::warm_state_t state_next;

  // address decode
  wire ctrl_wr  = reg_wr && (reg_addr == warmup_pkg::CTRL_OFS);
  wire pct_wr   = reg_wr && (reg_addr == warmup_pkg::PCT_OFS);
  wire sp_wr    = reg_wr && (reg_addr == warmup_pkg::SETPOINT_OFS);
  // the whole word is compared so that 200 clamps instead of wrapping
  wire [6:0] pct_in = (reg_wdata > 32'(warmup_pkg::PCT_MAX)) ?
                      warmup_pkg::PCT_MAX : reg_wdata[6:0];

  // feedback selection
  logic [23:0] sel_reading;
  logic        sel_sample;
  assign sel_reading = (sel_reg == 2'h0) ? reading_a :
                       (sel_reg == 2'h1) ? reading_b :
                       (sel_reg == 2'h2) ? reading_c : reading_d;
  assign sel_sample  = (sel_reg == 2'h0) ? sample_a :
                       (sel_reg == 2'h1) ? sample_b :
                       (sel_reg == 2'h2) ? sample_c : sample_d;

  // setpoint comparisons, widened so the hysteresis cannot wrap
  wire reached   = sel_reading >= setpoint_reg;
  wire cooled    = ({1'b0, sel_reading} + warmup_pkg::HYST_MK) <=
                   {1'b0, setpoint_reg};
  wire enabled   = mode_reg && range_reg;
  wire auto_stop = (state_reg == warmup_pkg::HEAT_ST) && enabled &&
                   sel_sample && reached && !policy_reg;

  // heater range: a software write wins over the hardware clear
  assign range_next = ctrl_wr   ? reg_wdata[warmup_pkg::RANGE_BIT] :
                      auto_stop ? 1'b0 : range_reg;

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg     <= warmup_pkg::MODE_RST;
      policy_reg   <= warmup_pkg::POLICY_RST;
      sel_reg      <= warmup_pkg::SEL_RST;
      range_reg    <= warmup_pkg::RANGE_RST;
      pct_reg      <= warmup_pkg::PCT_RST;
      setpoint_reg <= warmup_pkg::SETPOINT_RST;
    end else begin
      range_reg <= range_next;
      if (ctrl_wr) begin
        mode_reg   <= reg_wdata[warmup_pkg::MODE_BIT];
        policy_reg <= reg_wdata[warmup_pkg::POLICY_BIT];
        sel_reg    <= reg_wdata[warmup_pkg::SEL_LO +: 2];
      end
      if (pct_wr) begin
        pct_reg <= pct_in;
      end
      if (sp_wr) begin
        setpoint_reg <= reg_wdata[23:0];
      end
    end
  end

  // read mux, data valid only in the cycle after the strobe
  logic [31:0] rd_mux;
  assign rd_mux =
    (reg_addr == warmup_pkg::CTRL_OFS) ?
      {27'h0, range_reg, sel_reg, policy_reg, mode_reg} :
    (reg_addr == warmup_pkg::PCT_OFS) ? {25'h0, pct_reg} :
    (reg_addr == warmup_pkg::SETPOINT_OFS) ? {8'h0, setpoint_reg} :
    (reg_addr == warmup_pkg::STATUS_OFS) ?
      {last_reading_reg, 6'h0, range_reg, supply_on} : 32'h0;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // on/off state machine, decisions taken on each selected sample
  always_comb begin
    state_next = state_reg;
    if (!enabled) begin
      state_next = warmup_pkg::OFF_ST;
    end else begin
      unique case (state_reg)
        warmup_pkg::OFF_ST: begin
          state_next = warmup_pkg::HEAT_ST;
        end
        warmup_pkg::HEAT_ST: begin
          if (sel_sample && reached) begin
            state_next = policy_reg ? warmup_pkg::REST_ST :
                                      warmup_pkg::OFF_ST;
          end
        end
        warmup_pkg::REST_ST: begin
          if (sel_sample && cooled) begin
            state_next = warmup_pkg::HEAT_ST;
          end
        end
        default: begin
          state_next = warmup_pkg::OFF_ST;
        end
      endcase
    end
  end

  // scaled drive level
  logic [15:0] scaled_code;
  pct_scale scale_u (
    .pct  (pct_reg),
    .code (scaled_code)
  );

  // state, drive and last feedback reading
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg        <= warmup_pkg::OFF_ST;
      supply_on        <= 1'b0;
      supply_code      <= 16'h0;
      last_reading_reg <= 24'h0;
    end else begin
      state_reg   <= state_next;
      supply_on   <= state_next == warmup_pkg::HEAT_ST;
      supply_code <= (state_next == warmup_pkg::HEAT_ST) ?
                     scaled_code : 16'h0;
      if (sel_sample) begin
        last_reading_reg <= sel_reading;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  heat_level_a: assert property (supply_on |->
    supply_code == $past(scaled_code))
    else $error("drive level differs from scaled percentage");
  off_zero_a: assert property (!supply_on |-> supply_code == 16'h0)
    else $error("drive not zero while off");
  range_gate_a: assert property (!range_reg |=> !supply_on)
    else $error("drive on with heater range off");
  auto_stop_a: assert property (auto_stop && !ctrl_wr |=>
    !range_reg && !supply_on)
    else $error("auto-off did not stop and clear range");
  restart_a: assert property ((state_reg == warmup_pkg::OFF_ST) &&
    enabled |=> supply_on)
    else $error("range on did not start heating");
  cont_rest_a: assert property ((state_reg == warmup_pkg::HEAT_ST) &&
    enabled && policy_reg && sel_sample && reached && !ctrl_wr |=>
    !supply_on && range_reg)
    else $error("continuous stop wrong at setpoint");
  cont_keep_a: assert property (policy_reg && range_reg && !ctrl_wr |=>
    range_reg)
    else $error("continuous policy cleared heater range");
  reheat_a: assert property ((state_reg == warmup_pkg::REST_ST) &&
    enabled && sel_sample && cooled |=> supply_on)
    else $error("no reheat one kelvin below setpoint");
  sample_only_a: assert property ((state_reg == warmup_pkg::REST_ST) &&
    !sel_sample ##1 enabled |-> !supply_on)
    else $error("output changed without a sample");
  select_a: assert property (
    sel_reg == 2'h1 |-> sel_reading == reading_b)
    else $error("wrong feedback input selected");

  auto_cycle_c: cover property (auto_stop ##[1:50] supply_on);
  reheat_c: cover property ((state_reg == warmup_pkg::REST_ST)
    ##1 (state_reg == warmup_pkg::HEAT_ST));
  zero_pct_c: cover property (supply_on && pct_reg == 7'h0);

endmodule
